// file: dv/tksem_dev_model.sv
/*
  tksem_dev_model: the device's eight token flags, host on the left port.
  Assumes the bench drives the right side through a plain write strobe.
*/
`timescale 1ns/100ps
module tksem_dev_model (
  // left port pins
  input wire logic sel_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [2:0] idx_in,
  input wire logic [15:0] d_in,
  output logic [15:0] q_out,
  // right side request
  input wire logic r_we_in,
  input wire logic [2:0] r_idx_in,
  input wire logic r_bit_in
);
  // owner 0 free, 1 left, 2 right; power-up junk, so init must clear it
  logic [1:0] own [8] = '{default: 2'h2};
  // one request latch per side and flag; zero is a pending request
  logic lreq [8] = '{default: 1'b0};
  logic rreq [8] = '{default: 1'b0};
  logic q_r = 1'b1;
  logic wr_on = 1'b0;
  // a strobe counts only if it fell while the flags were selected
  always @(negedge we_n_in)
    wr_on = !sel_n_in;
  // left write lands when strobe or select ends, whichever is first;
  // select and strobe rise together, so neither alone is trusted
  always @(posedge (we_n_in | sel_n_in))
    if (wr_on)
    begin
      wr_on = 1'b0;
      lreq[idx_in] = d_in[0];
      if (!d_in[0] && own[idx_in] == 2'h0)
        own[idx_in] = 2'h1;
      if (d_in[0] && own[idx_in] == 2'h1)
        own[idx_in] = rreq[idx_in] ? 2'h0 : 2'h2;
    end
  // right request latch; a pending left zero takes a freed token
  always @(negedge r_we_in)
  begin
    rreq[r_idx_in] = r_bit_in;
    if (!r_bit_in && own[r_idx_in] == 2'h0)
      own[r_idx_in] = 2'h2;
    if (r_bit_in && own[r_idx_in] == 2'h2)
      own[r_idx_in] = lreq[r_idx_in] ? 2'h0 : 2'h1;
  end
  // frozen while select and enable stay low; bus is never the array
  always @(negedge (sel_n_in | oe_n_in))
    q_r = (own[idx_in] != 2'h1);
  // a released bus shows the inverse, so stale data cannot pass
  assign q_out = (sel_n_in | oe_n_in) ? {16{~q_r}} : {16{q_r}};
endmodule : tksem_dev_model

// file: dv/tksem_host_bench.sv
/*
  tksem_host_bench: host controller against the flag model.
  Assumes tksem_pkg and tksem_host are compiled first.
*/
`timescale 1ns/100ps
`define CHK(a, b) \
  begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module tksem_host_bench;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  tksem_pkg::tksem_cmd_type cmd_op_in = tksem_pkg::TKSEM_CMD_POLL;
  logic [2:0] cmd_index_in = 3'h0;
  logic ready, done, granted, sel_n, ce_n, we_n, oe_n, doe;
  logic [2:0] idx;
  logic [15:0] dq;
  logic [15:0] din;
  logic r_we = 1'b0;
  logic [2:0] r_idx = 3'h0;
  logic r_bit = 1'b1;
  int errors = 0;
  int n_checks = 0;
  always #2 mclk_in = ~mclk_in;
  tksem_host u_tksem_host (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
    .cmd_index_in(cmd_index_in), .cmd_ready_out(ready), .done_out(done),
    .granted_out(granted), .token_space_select_n_out(sel_n),
    .chip_enable_n_out(ce_n), .write_n_out(we_n),
    .out_enable_n_out(oe_n), .flag_index_out(idx), .data_out(dq),
    .data_oe_out(doe), .data_in(din));
  tksem_dev_model u_tksem_dev_model (.sel_n_in(sel_n), .we_n_in(we_n),
    .oe_n_in(oe_n), .idx_in(idx), .d_in(dq), .q_out(din),
    .r_we_in(r_we), .r_idx_in(r_idx), .r_bit_in(r_bit));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // one command, bounded wait for done, then latency and result
  task automatic run(input tksem_pkg::tksem_cmd_type op,
    input logic [2:0] ix, input int lat, input logic g);
    int n;
    n = 0;
    @(posedge mclk_in);
    cmd_op_in <= op;
    cmd_index_in <= ix;
    cmd_valid_in <= 1'b1;
    @(posedge mclk_in);
    cmd_valid_in <= 1'b0;
    do
    begin
      @(negedge mclk_in);
      n++;
    end
    while (done !== 1'b1 && n < 300);
    if (n >= 300)
    begin
      errors++;
      report_and_stop();
    end
    `CHK(n - 1, lat)
    `CHK(granted, g)
    `CHK(ce_n, 1'b1)
    `CHK(ready, 1'b1)
    `CHK(sel_n, 1'b1)
    `CHK(doe, 1'b0)
    `CHK(idx, (op == tksem_pkg::TKSEM_CMD_INIT) ? 3'h7 : ix)
    `CHK(dq, (op == tksem_pkg::TKSEM_CMD_ACQUIRE) ? 16'h0000 : 16'h0001)
  endtask : run
  // right side writes one request bit
  task automatic rwr(input logic [2:0] ix, input logic b);
    @(posedge mclk_in);
    r_idx <= ix;
    r_bit <= b;
    r_we <= 1'b1;
    @(posedge mclk_in);
    r_we <= 1'b0;
  endtask : rwr
  // both sides clear every latch, then each flag is free to the left
  task automatic t_init;
    run(tksem_pkg::TKSEM_CMD_INIT, 3'h0, 105, 1'b0);
    for (int i = 0; i < 8; i++)
      rwr(i[2:0], 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      run(tksem_pkg::TKSEM_CMD_ACQUIRE, i[2:0], 22, 1'b1);
      run(tksem_pkg::TKSEM_CMD_RELEASE, i[2:0], 14, 1'b0);
    end
  endtask : t_init
  // lockout, hand-over on release and a pending request winning later
  task automatic t_handover;
    run(tksem_pkg::TKSEM_CMD_ACQUIRE, 3'h3, 22, 1'b1);
    rwr(3'h3, 1'b0);
    run(tksem_pkg::TKSEM_CMD_POLL, 3'h3, 12, 1'b1);
    run(tksem_pkg::TKSEM_CMD_RELEASE, 3'h3, 14, 1'b0);
    run(tksem_pkg::TKSEM_CMD_POLL, 3'h3, 12, 1'b0);
    run(tksem_pkg::TKSEM_CMD_ACQUIRE, 3'h3, 22, 1'b0);
    rwr(3'h3, 1'b1);
    run(tksem_pkg::TKSEM_CMD_POLL, 3'h3, 12, 1'b1);
    run(tksem_pkg::TKSEM_CMD_RELEASE, 3'h3, 14, 1'b0);
  endtask : t_handover
  initial
  begin
    repeat (8) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    t_init();
    t_handover();
    report_and_stop();
  end
endmodule : tksem_host_bench

// file: logic/tksem_host.sv
/*
  tksem_host: drives one port's token semaphore pins of a dual-port RAM.
  Assumes pins are synchronous to mclk_in and the device meets the strobe
  widths in tksem_pkg; the RAM array itself is never selected.
*/
`timescale 1ns/100ps

module tksem_host #(
  parameter int unsigned DATA_W = 16
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // command port
  input wire logic cmd_valid_in,
  input wire tksem_pkg::tksem_cmd_type cmd_op_in,
  input wire logic [2:0] cmd_index_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic granted_out,
  // device pins
  output logic token_space_select_n_out,
  output logic chip_enable_n_out,
  output logic write_n_out,
  output logic out_enable_n_out,
  output logic [2:0] flag_index_out,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_out,
  input wire logic [DATA_W-1:0] data_in
);
  typedef enum logic [2:0] {
    TKSEM_IDLE, TKSEM_SETUP, TKSEM_WRITE, TKSEM_GAP, TKSEM_READ,
    TKSEM_DONE
  } tksem_state_type;

  typedef struct packed {
    tksem_state_type st;
    tksem_pkg::tksem_cmd_type op;
    logic [2:0] idx;
    logic [3:0] cnt;
    logic wval;
    logic done;
    logic grant;
  } tksem_regs_type;

  logic rst_m_r;
  logic rst_s_r;
  tksem_regs_type q_r;
  tksem_regs_type q_nxt;

  // reset release through two flops
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  // sequencer: setup, write pulse, gap, then read with select+oe low for acquire; poll skips write and gap, release and init skip the read
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    unique case (q_r.st)
      TKSEM_IDLE:
      begin
        if (cmd_valid_in)
        begin
          q_nxt.op = cmd_op_in;
          q_nxt.idx = cmd_index_in;
          // acquire requests with zero, release and init write one
          q_nxt.wval = (cmd_op_in != tksem_pkg::TKSEM_CMD_ACQUIRE);
          q_nxt.cnt = 4'(tksem_pkg::SETUP_CYC);
          q_nxt.st = TKSEM_SETUP;
        end
      end
      TKSEM_SETUP:
      begin
        if (q_r.cnt <= 4'h1)
        begin
          // a poll never writes, so a pending request is kept
          if (q_r.op == tksem_pkg::TKSEM_CMD_POLL)
          begin
            q_nxt.cnt = 4'(tksem_pkg::READ_CYC);
            q_nxt.st = TKSEM_READ;
          end
          else
          begin
            q_nxt.cnt = 4'(tksem_pkg::WRITE_CYC);
            q_nxt.st = TKSEM_WRITE;
          end
        end
        else
          q_nxt.cnt = q_r.cnt - 4'h1;
      end
      TKSEM_WRITE:
      begin
        if (q_r.cnt <= 4'h1)
        begin
          q_nxt.cnt = 4'(tksem_pkg::GAP_CYC);
          q_nxt.st = TKSEM_GAP;
        end
        else
          q_nxt.cnt = q_r.cnt - 4'h1;
      end
      TKSEM_GAP:
      begin
        // select dropped here, so the next read relatches
        if (q_r.cnt <= 4'h1)
        begin
          if (q_r.op == tksem_pkg::TKSEM_CMD_INIT &&
              q_r.idx != 3'h7)
          begin
            q_nxt.idx = q_r.idx + 3'h1;
            q_nxt.cnt = 4'(tksem_pkg::SETUP_CYC);
            q_nxt.st = TKSEM_SETUP;
          end
          else if (q_r.op == tksem_pkg::TKSEM_CMD_ACQUIRE)
          begin
            q_nxt.cnt = 4'(tksem_pkg::READ_CYC);
            q_nxt.st = TKSEM_READ;
          end
          else
            q_nxt.st = TKSEM_DONE;
        end
        else
          q_nxt.cnt = q_r.cnt - 4'h1;
      end
      TKSEM_READ:
      begin
        if (q_r.cnt <= 4'h1)
        begin
          // only bit zero is looked at; all bits carry the flag
          q_nxt.grant = ~data_in[0];
          q_nxt.st = TKSEM_DONE;
        end
        else
          q_nxt.cnt = q_r.cnt - 4'h1;
      end
      TKSEM_DONE:
      begin
        // idle is at least one cycle with select high between reads
        q_nxt.done = 1'b1;
        q_nxt.st = TKSEM_IDLE;
      end
      default:
        q_nxt.st = TKSEM_IDLE;
    endcase
    if (q_r.op == tksem_pkg::TKSEM_CMD_RELEASE &&
        q_r.st == TKSEM_DONE)
      q_nxt.grant = 1'b0;
  end

  always_ff @(posedge mclk_in or negedge rst_s_r)
  begin
    if (!rst_s_r)
    begin
      q_r <= '{st: TKSEM_IDLE, op: tksem_pkg::TKSEM_CMD_ACQUIRE,
               idx: 3'h0, cnt: 4'h0, wval: 1'b1,
               done: 1'b0, grant: 1'b0};
    end
    else
      q_r <= q_nxt;
  end

  // pin drive; chip enable kept high so the array stays untouched
  assign chip_enable_n_out = 1'b1;
  assign token_space_select_n_out = !(q_r.st == TKSEM_SETUP ||
    q_r.st == TKSEM_WRITE || q_r.st == TKSEM_READ);
  assign write_n_out = (q_r.st != TKSEM_WRITE);
  assign out_enable_n_out = (q_r.st != TKSEM_READ);
  assign flag_index_out = q_r.idx;
  assign data_out = {{(DATA_W-1){1'b0}}, q_r.wval};
  assign data_oe_out = (q_r.st == TKSEM_WRITE);
  assign cmd_ready_out = (q_r.st == TKSEM_IDLE);
  assign done_out = q_r.done;
  assign granted_out = q_r.grant;

  sequence wr_phase_s;
    !write_n_out [*7];
  endsequence
  sequence gap_phase_s;
    write_n_out && token_space_select_n_out;
  endsequence

  write_width_a: assert property (
    @(posedge mclk_in) disable iff (!rst_s_r)
    $fell(write_n_out) |-> wr_phase_s ##1 gap_phase_s)
    else $error("write pulse width wrong");
  read_gap_a: assert property (
    @(posedge mclk_in) disable iff (!rst_s_r)
    $rose(out_enable_n_out) |-> token_space_select_n_out)
    else $error("no select gap after read");
  array_off_a: assert property (
    @(posedge mclk_in) disable iff (!rst_s_r)
    chip_enable_n_out)
    else $error("array selected");
  acq_order_a: assert property (
    @(posedge mclk_in) disable iff (!rst_s_r)
    (q_r.st == TKSEM_WRITE && !q_r.wval) |-> ##[1:20] !out_enable_n_out)
    else $error("acquire not read back");
  data_bit_a: assert property (
    @(posedge mclk_in) disable iff (!rst_s_r)
    data_oe_out |-> data_out[DATA_W-1:1] == '0)
    else $error("upper data bits driven");
  oe_sel_a: assert property (
    @(posedge mclk_in) disable iff (!rst_s_r)
    !out_enable_n_out |-> !token_space_select_n_out && write_n_out)
    else $error("read without select");
  init_all_a: assert property (
    @(posedge mclk_in) disable iff (!rst_s_r)
    (q_r.op == tksem_pkg::TKSEM_CMD_INIT && $fell(write_n_out))
    |-> data_out[0])
    else $error("init wrote zero");
  grant_src_a: assert property (
    @(posedge mclk_in) disable iff (!rst_s_r)
    $rose(granted_out) |-> !$past(data_in[0]))
    else $error("grant without zero read");
endmodule : tksem_host

// file: logic/tksem_pkg.sv
/*
  tksem_pkg: constants for the host-side token semaphore controller.
  Assumes one 250 MHz clock and an asynchronous dual-port RAM port outside.
*/
package tksem_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  // strobe widths in ns, least times, rounded up to whole cycles
  localparam int unsigned SETUP_NS = 10;
  localparam int unsigned WRITE_NS = 25;
  localparam int unsigned READ_NS = 30;
  localparam int unsigned GAP_NS = 10;
  localparam int unsigned SETUP_CYC =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_CYC =
    (WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYC =
    (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYC =
    (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned FLAG_COUNT = 8;
  localparam int unsigned INDEX_W = 3;
  // host command codes
  typedef enum logic [1:0] {
    TKSEM_CMD_ACQUIRE,
    TKSEM_CMD_RELEASE,
    TKSEM_CMD_POLL,
    TKSEM_CMD_INIT
  } tksem_cmd_type;
endpackage : tksem_pkg
